// ### src/bcs_pkg.sv
// Purpose: Constants for the bus cycle sequencer
// Assumes: One 125 MHz clock; half states are clk_sys cycles
// Notes: One bus T state spans two clk_sys cycles (rise half, fall half)
// Function
// - Machine cycle is three to six states
// - Opcode fetch lasts four to six states
// - Data cycles last three to five states
// - Wait sampled at T2 fall and waits
// - Fetch: address and strobes change on the same edge
// - Capture fetch data at T3 rise
// - Refresh address and strobe in T3, T4
// - Memory read/write three states plus waits
// - Write strobe released half state early
// - I/O cycles add one automatic wait
// - Bus request sampled at last state
// - Grant within one machine cycle
// - No interrupts while bus is granted
// - Interrupt sampled at instruction end, gated
// - Acknowledge uses I/O request, reads vector
// - Acknowledge adds two automatic waits
// - Grant after lines go high impedance
// - Refresh counter low seven bits increment
// - First-cycle indicator with fetch and acknowledge
package bcs_pkg;
  typedef enum logic [2:0] {
    BCS_CMD_FETCH = 3'h0,
    BCS_CMD_MEM_RD = 3'h1,
    BCS_CMD_MEM_WR = 3'h2,
    BCS_CMD_IO_RD = 3'h3,
    BCS_CMD_IO_WR = 3'h4
  } bcs_cmd_e;
  localparam logic [2:0] BCS_FETCH_MIN = 3'h4;
  localparam logic [2:0] BCS_FETCH_MAX = 3'h6;
  localparam logic [2:0] BCS_DATA_MIN = 3'h3;
  localparam logic [2:0] BCS_DATA_MAX = 3'h5;
  localparam logic [1:0] BCS_IO_AUTO_WAITS = 2'h1;
  localparam logic [1:0] BCS_ACK_AUTO_WAITS = 2'h2;
  localparam logic [6:0] BCS_REFRESH_STROBE_N_STEP = 7'h01;
  localparam logic [7:0] BCS_REFRESH_STROBE_N_RESET = 8'h00;
  localparam logic [7:0] BCS_PAGE_RESET = 8'h00;
endpackage : bcs_pkg

// ### src/bcs_phase_if.sv
`timescale 1ns/100ps
// Purpose: Half-state phase carrier between sequencer and divider
// Assumes: Single clk_sys domain
// Notes: rise marks first half of a state, fall the second
interface bcs_phase_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface : bcs_phase_if

// ### src/bcs_phase_gen.sv
`timescale 1ns/100ps
// Purpose: Split clk_sys into alternating state halves
// Assumes: Reset starts on a rising half
// Notes: Pulses are one clk_sys cycle wide
module bcs_phase_gen (
  input wire logic clk_sys,
  input wire logic arst_n,
  bcs_phase_if.src ph
);
  logic half_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  assign ph.rise = ~half_q;
  assign ph.fall = half_q;
endmodule : bcs_phase_gen

// ### src/bcs_sequencer.sv
`timescale 1ns/100ps
// Purpose: External bus machine cycle sequencer
// Assumes: Inputs synchronous to clk_sys; two clk_sys per bus state
// Notes: Each bus state = rise half then fall half; pins change per half
module bcs_sequencer (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cyc_valid,
  input wire bcs_pkg::bcs_cmd_e cyc_cmd,
  input wire logic [15:0] cyc_addr,
  input wire logic [7:0] cyc_wdata,
  input wire logic [2:0] cyc_extra,
  input wire logic cyc_last,
  input wire logic int_enable_latch,
  input wire logic refresh_strobe_n_load,
  input wire logic [7:0] refresh_strobe_n_load_val,
  input wire logic [7:0] int_page,
  input wire logic wait_n,
  input wire logic bus_request_n,
  input wire logic int_n,
  input wire logic nmi_n,
  input wire logic [7:0] data_in,
  output logic cyc_ready,
  output logic cyc_done,
  output logic [7:0] cyc_rdata,
  output logic int_ack,
  output logic nmi_take,
  output logic [15:0] addr_out,
  output logic addr_oe,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic ctrl_oe,
  output logic memory_request_n,
  output logic io_request_n,
  output logic rd_n,
  output logic wr_n,
  output logic refresh_strobe_n,
  output logic first_cycle_indicator_n,
  output logic bus_grant_n,
  output logic [7:0] refresh_strobe_n_count
);
  import bcs_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RUN = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_HOLD = 5'b01000,
    ST_GRANT = 5'b10000
  } bcs_state_e;

  bcs_phase_if ph ();

  bcs_phase_gen u_phase (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ph(ph)
  );

  bcs_state_e state_q;
  bcs_cmd_e cmd_q;
  logic ack_q;
  logic last_q;
  logic [2:0] tstate_q;
  logic [2:0] len_q;
  logic [1:0] auto_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] refresh_strobe_n_q;
  logic [7:0] rdata_q;
  logic wait_smp_q;
  logic is_fetch;
  logic is_write;
  logic is_io;
  logic last_state;
  logic take_int;
  logic take_nmi;
  logic nmi_prev_q;
  logic nmi_pend_q;
  logic [2:0] len_d;

  assign is_fetch = (cmd_q == BCS_CMD_FETCH) | ack_q;
  assign is_write = (cmd_q == BCS_CMD_MEM_WR) | (cmd_q == BCS_CMD_IO_WR);
  assign is_io = (cmd_q == BCS_CMD_IO_RD) | (cmd_q == BCS_CMD_IO_WR);
  assign last_state = (tstate_q == len_q);

  // Extra states clamp to documented ranges
  always_comb begin
    if (cyc_cmd == BCS_CMD_FETCH) begin
      len_d = BCS_FETCH_MIN + cyc_extra;
      if (len_d > BCS_FETCH_MAX || len_d < BCS_FETCH_MIN) begin
        len_d = BCS_FETCH_MAX;
      end
    end else begin
      len_d = BCS_DATA_MIN + cyc_extra;
      if (len_d > BCS_DATA_MAX || len_d < BCS_DATA_MIN) begin
        len_d = BCS_DATA_MAX;
      end
    end
  end

  // Gated at instruction end; bus request takes priority
  assign take_nmi = nmi_pend_q & bus_request_n & last_q;
  assign take_int = ~int_n & int_enable_latch & bus_request_n
                    & last_q & ~take_nmi;

  // Falling edge latch of nmi_n between instructions
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      nmi_prev_q <= 1'b1;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_n;
      if (nmi_prev_q & ~nmi_n) begin
        nmi_pend_q <= 1'b1;
      end else if (nmi_take) begin
        nmi_pend_q <= 1'b0;
      end
    end
  end

  // Sequencing of states, waits and bus hand-over
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cmd_q <= BCS_CMD_FETCH;
      ack_q <= 1'b0;
      last_q <= 1'b0;
      tstate_q <= 3'h1;
      len_q <= BCS_FETCH_MIN;
      auto_q <= 2'h0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      wait_smp_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (ph.rise && !bus_request_n) begin
            state_q <= ST_HOLD;
          end else if (ph.fall && bus_request_n
                       && (take_int || cyc_valid)) begin
            // Taken on a fall half so that T1 opens on a rise half
            state_q <= ST_RUN;
            ack_q <= take_int;
            cmd_q <= take_int ? BCS_CMD_FETCH : cyc_cmd;
            len_q <= take_int ? BCS_FETCH_MIN : len_d;
            last_q <= take_int ? 1'b0 : cyc_last;
            addr_q <= cyc_addr;
            wdata_q <= cyc_wdata;
            tstate_q <= 3'h1;
            auto_q <= take_int ? BCS_ACK_AUTO_WAITS
                    : ((cyc_cmd == BCS_CMD_IO_RD ||
                        cyc_cmd == BCS_CMD_IO_WR)
                       ? BCS_IO_AUTO_WAITS : 2'h0);
          end
        end
        ST_RUN: begin
          if (ph.fall && tstate_q == 3'h2) begin
            wait_smp_q <= ~wait_n;
          end
          if (ph.fall) begin
            if (tstate_q == 3'h2 && (auto_q != 2'h0 || !wait_n)) begin
              state_q <= ST_WAIT;
            end else if (last_state) begin
              // Bus request seen at last state fall
              state_q <= bus_request_n ? ST_IDLE : ST_HOLD;
              if (is_fetch || ack_q) begin
                ack_q <= 1'b0;
              end
            end else begin
              tstate_q <= tstate_q + 3'h1;
            end
          end
        end
        ST_WAIT: begin
          if (ph.fall) begin
            wait_smp_q <= ~wait_n;
            if (auto_q != 2'h0) begin
              auto_q <= auto_q - 2'h1;
            end
            if (auto_q <= 2'h1 && wait_n) begin
              state_q <= ST_RUN;
              tstate_q <= 3'h3;
            end
          end
        end
        ST_HOLD: begin
          if (ph.rise) begin
            state_q <= ST_GRANT;
          end
        end
        ST_GRANT: begin
          if (ph.rise && bus_request_n) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Refresh counter: low seven bits count, top bit held
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      refresh_strobe_n_q <= BCS_REFRESH_STROBE_N_RESET;
    end else if (refresh_strobe_n_load) begin
      refresh_strobe_n_q <= refresh_strobe_n_load_val;
    end else if (state_q == ST_RUN && is_fetch && ph.fall
                 && last_state) begin
      refresh_strobe_n_q <= {refresh_strobe_n_q[7], refresh_strobe_n_q[6:0] + BCS_REFRESH_STROBE_N_STEP};
    end
  end

  // Data capture at T3 rise; vector read on acknowledge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
      cyc_done <= 1'b0;
      int_ack <= 1'b0;
      nmi_take <= 1'b0;
      cyc_ready <= 1'b0;
    end else begin
      cyc_done <= 1'b0;
      int_ack <= 1'b0;
      nmi_take <= ph.rise && state_q == ST_IDLE && take_nmi
                  && !nmi_take;
      cyc_ready <= (state_q == ST_IDLE) && bus_request_n;
      if (state_q == ST_RUN && ph.rise && tstate_q == 3'h3) begin
        if (!is_write) begin
          rdata_q <= data_in;
        end
        cyc_done <= ~ack_q;
        int_ack <= ack_q;
      end
    end
  end

  // Pin drivers registered from the state one half ahead
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addr_out <= 16'h0000;
      addr_oe <= 1'b0;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      ctrl_oe <= 1'b0;
      memory_request_n <= 1'b1;
      io_request_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      refresh_strobe_n <= 1'b1;
      first_cycle_indicator_n <= 1'b1;
      bus_grant_n <= 1'b1;
    end else begin
      bus_grant_n <= ~(state_q == ST_GRANT);
      addr_oe <= ~(state_q == ST_HOLD || state_q == ST_GRANT);
      ctrl_oe <= ~(state_q == ST_HOLD || state_q == ST_GRANT);
      if (state_q == ST_RUN || state_q == ST_WAIT) begin
        // Data enabled at T1 rise, with or before the write strobe, never after it
        data_oe <= is_write && !is_fetch;
        data_out <= wdata_q;
        if (is_fetch && tstate_q >= 3'h3) begin
          addr_out <= {int_page, 1'b0, refresh_strobe_n_q[6:0]};
          refresh_strobe_n <= 1'b0;
          rd_n <= 1'b1;
          io_request_n <= 1'b1;
          first_cycle_indicator_n <= 1'b1;
          // Held low until the last refresh state, then dropped
          memory_request_n <= (tstate_q == len_q);
        end else begin
          addr_out <= addr_q;
          refresh_strobe_n <= 1'b1;
          first_cycle_indicator_n <= ~is_fetch;
          if (ph.rise && tstate_q == 3'h1) begin
            // Strobes asserted on the same edge as the address, except I/O write and acknowledge strobes at T2 rise
            memory_request_n <= ~(!is_io && !ack_q);
            io_request_n <= ~is_io;
            rd_n <= ~(!is_write && !ack_q);
            wr_n <= ~(is_write && !is_io);
          end else if (ph.rise && tstate_q == 3'h2 && ack_q) begin
            io_request_n <= 1'b0;
          end else if (ph.rise && tstate_q == 3'h2 && is_io) begin
            wr_n <= ~is_write;
          end else if (ph.fall && last_state && state_q == ST_RUN
                       && !is_fetch) begin
            // Write drops at least a state and a half before address change
            memory_request_n <= 1'b1;
            io_request_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
          end
        end
      end else begin
        refresh_strobe_n <= 1'b1;
        first_cycle_indicator_n <= 1'b1;
        memory_request_n <= 1'b1;
        io_request_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        data_oe <= 1'b0;
      end
    end
  end

  assign cyc_rdata = rdata_q;
  assign refresh_strobe_n_count = refresh_strobe_n_q;
endmodule : bcs_sequencer

// ### test/bcs_seq_chk.sv
// Purpose: Port checker for bcs_sequencer
// Assumes: Single clk_sys domain
// Notes: Bound below to every sequencer instance
`timescale 1ns/100ps
module bcs_seq_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic memory_request_n,
  input wire logic io_request_n,
  input wire logic refresh_strobe_n,
  input wire logic first_cycle_indicator_n,
  input wire logic bus_grant_n,
  input wire logic addr_oe,
  input wire logic data_oe,
  input wire logic ctrl_oe,
  input wire logic [15:0] addr_out,
  input wire logic [7:0] int_page,
  input wire logic [7:0] refresh_strobe_n_count,
  input wire logic refresh_strobe_n_load,
  input wire logic int_ack,
  input wire logic cyc_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence refresh_strobe_n_go;
    $fell(refresh_strobe_n);
  endsequence
  sequence rd_quiet;
    rd_n [*4];
  endsequence
  chk_rd_in_refresh: assert property (!refresh_strobe_n |-> rd_n)
    else $error("read strobe during refresh");
  chk_refresh_rd_idle: assert property (refresh_strobe_n_go |-> rd_quiet)
    else $error("read strobe inside refresh slot");
  chk_refresh_page: assert property (!refresh_strobe_n && !memory_request_n
    |-> addr_out[15:8] == int_page)
    else $error("refresh upper address wrong");
  chk_grant_float: assert property (!bus_grant_n
    |-> !addr_oe && !data_oe && !ctrl_oe)
    else $error("grant while lines driven");
  chk_grant_no_int: assert property (!bus_grant_n |-> !int_ack)
    else $error("interrupt taken during grant");
  chk_write_data: assert property (!wr_n |-> data_oe && rd_n)
    else $error("write strobe without data");
  chk_write_in_req: assert property (!wr_n
    |-> !memory_request_n || !io_request_n)
    else $error("write strobe outside request");
  chk_ack_no_memory_request_n: assert property (!io_request_n &&
    !first_cycle_indicator_n |-> memory_request_n)
    else $error("memory request during acknowledge");
  chk_refresh_strobe_n_step: assert property ($changed(refresh_strobe_n_count) && !$past(refresh_strobe_n_load)
    |-> refresh_strobe_n_count[6:0] == $past(refresh_strobe_n_count[6:0]) + 7'h01
    && refresh_strobe_n_count[7] == $past(refresh_strobe_n_count[7]))
    else $error("refresh counter step wrong");
endmodule : bcs_seq_chk
bind bcs_sequencer bcs_seq_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .rd_n(rd_n), .wr_n(wr_n), .memory_request_n(memory_request_n),
  .io_request_n(io_request_n), .refresh_strobe_n(refresh_strobe_n),
  .first_cycle_indicator_n(first_cycle_indicator_n),
  .bus_grant_n(bus_grant_n), .addr_oe(addr_oe), .data_oe(data_oe),
  .ctrl_oe(ctrl_oe), .addr_out(addr_out), .int_page(int_page),
  .refresh_strobe_n_count(refresh_strobe_n_count), .refresh_strobe_n_load(refresh_strobe_n_load), .int_ack(int_ack),
  .cyc_done(cyc_done));

// ### test/bcs_bus_model.sv
// Purpose: Memory, port and vector source on the far bus side
// Assumes: Strobes active low, sampled on clk_sys
// Notes: Released data bus shows inverted last value
`timescale 1ns/100ps
module bcs_bus_model #(parameter logic [7:0] VEC = 8'hc4) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [15:0] addr_out,
  input wire logic [7:0] data_out,
  input wire logic memory_request_n,
  input wire logic io_request_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic first_cycle_indicator_n,
  input wire logic [2:0] n_waits,
  output logic wait_n,
  output logic [7:0] data_in,
  output logic [7:0] wr_seen
);
  logic [4:0] cnt_q;
  logic [7:0] last_q;
  logic sel;
  logic ack;
  // Refresh slot acted on only under memory request
  assign sel = !memory_request_n || !io_request_n;
  assign ack = !io_request_n && !first_cycle_indicator_n;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) cnt_q <= 5'h00;
    else cnt_q <= sel ? cnt_q + 5'h01 : 5'h00;
  end
  // Low across 2n+1 clocks so either sample phase sees n waits
  assign wait_n = !(sel && !ack && n_waits != 3'h0 &&
    cnt_q <= {1'b0, n_waits, 1'b0});
  assign data_in = ack ? VEC : (!rd_n && sel) ?
    addr_out[7:0] ^ 8'h5a : ~last_q;
  always_ff @(posedge clk_sys) begin
    last_q <= data_in;
    if (!wr_n && sel) wr_seen <= data_out;
  end
endmodule : bcs_bus_model

// ### test/testbench.sv
// Purpose: Self-checking bench for bcs_sequencer
// Assumes: 125 MHz clk_sys, async active-low reset
// Notes: Latencies compared as differences between cycle kinds
`timescale 1ns/100ps
module testbench;
  import bcs_pkg::*;
  logic clk_sys = 0, arst_n = 0, cyc_valid = 0, cyc_last = 0, ien = 0;
  logic refresh_strobe_n_load = 0, bus_request_n = 1, int_n = 1, wait_n, cyc_ready;
  logic cyc_done, int_ack, addr_oe, bus_grant_n, rd_n, wr_n, memory_request_n_n, io_n;
  logic m1_n;
  bcs_cmd_e cyc_cmd = BCS_CMD_FETCH;
  logic [15:0] cyc_addr = 16'h0000, addr_out;
  logic [7:0] cyc_wdata = 8'h00, refresh_strobe_n_load_val = 8'h00, data_in, data_out;
  logic [7:0] cyc_rdata, refresh_strobe_n_count, wr_seen, rd;
  logic [2:0] n_waits = 3'h0;
  int n_fail = 0, n_checks = 0, lat, l_mem, l_fetch;
  logic akd;
  always #4 clk_sys = ~clk_sys;
  bcs_sequencer uut (.clk_sys(clk_sys), .arst_n(arst_n),
    .cyc_valid(cyc_valid), .cyc_cmd(cyc_cmd), .cyc_addr(cyc_addr),
    .cyc_wdata(cyc_wdata), .cyc_extra(3'h0), .cyc_last(cyc_last),
    .int_enable_latch(ien), .refresh_strobe_n_load(refresh_strobe_n_load),
    .refresh_strobe_n_load_val(refresh_strobe_n_load_val), .int_page(8'h3c), .wait_n(wait_n),
    .bus_request_n(bus_request_n), .int_n(int_n), .nmi_n(1'b1),
    .data_in(data_in), .cyc_ready(cyc_ready), .cyc_done(cyc_done),
    .cyc_rdata(cyc_rdata), .int_ack(int_ack), .nmi_take(),
    .addr_out(addr_out), .addr_oe(addr_oe), .data_out(data_out),
    .data_oe(), .ctrl_oe(), .memory_request_n(memory_request_n_n),
    .io_request_n(io_n), .rd_n(rd_n), .wr_n(wr_n), .refresh_strobe_n(),
    .first_cycle_indicator_n(m1_n), .bus_grant_n(bus_grant_n),
    .refresh_strobe_n_count(refresh_strobe_n_count));
  bcs_bus_model model (.clk_sys(clk_sys), .arst_n(arst_n),
    .addr_out(addr_out), .data_out(data_out), .memory_request_n(memory_request_n_n),
    .io_request_n(io_n), .rd_n(rd_n), .wr_n(wr_n),
    .first_cycle_indicator_n(m1_n), .n_waits(n_waits), .wait_n(wait_n),
    .data_in(data_in), .wr_seen(wr_seen));
  task automatic check(input string what, input logic [15:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // Latency counted from take, so rise-half alignment drops out
  task automatic run(input bcs_cmd_e c, input logic [15:0] a,
    input logic l);
    @(posedge clk_sys);
    cyc_cmd <= c;
    cyc_addr <= a;
    cyc_wdata <= a[15:8];
    cyc_last <= l;
    cyc_valid <= 1'b1;
    lat = 0;
    do begin @(posedge clk_sys); #1; lat++; end while (cyc_ready && lat < 50);
    @(posedge clk_sys);
    cyc_valid <= 1'b0;
    lat = 1;
    do begin @(posedge clk_sys); #1; lat++; end
    while (!cyc_done && !int_ack && lat < 200);
    rd = cyc_rdata;
    akd = int_ack;
    for (int i = 0; i < 40 && !cyc_ready; i++) @(posedge clk_sys) #1;
  endtask : run
  task automatic t_fetch();
    @(posedge clk_sys);
    refresh_strobe_n_load <= 1'b1;
    refresh_strobe_n_load_val <= 8'hff;
    @(posedge clk_sys);
    refresh_strobe_n_load <= 1'b0;
    run(BCS_CMD_FETCH, 16'h1234, 1'b0);
    l_fetch = lat;
    check("fetch data", 16'h006e, 16'(rd));
    check("refresh count", 16'h0080, 16'(refresh_strobe_n_count));
  endtask : t_fetch
  task automatic t_mem_io();
    run(BCS_CMD_MEM_RD, 16'h00a1, 1'b0);
    l_mem = lat;
    check("read data", 16'h00fb, 16'(rd));
    n_waits <= 3'h2;
    run(BCS_CMD_MEM_RD, 16'h00a2, 1'b0);
    n_waits <= 3'h0;
    check("wait stretch", 16'h0004, 16'(lat - l_mem));
    check("waited data", 16'h00f8, 16'(rd));
    run(BCS_CMD_IO_RD, 16'h0033, 1'b0);
    check("io auto wait", 16'h0002, 16'(lat - l_mem));
    check("io data", 16'h0069, 16'(rd));
    run(BCS_CMD_IO_WR, 16'h9d40, 1'b0);
    check("io write", 16'h009d, 16'(wr_seen));
    run(BCS_CMD_MEM_WR, 16'h6240, 1'b0);
    check("mem write", 16'h0062, 16'(wr_seen));
  endtask : t_mem_io
  task automatic t_int();
    @(posedge clk_sys);
    int_n <= 1'b0;
    run(BCS_CMD_FETCH, 16'h0010, 1'b1);
    run(BCS_CMD_MEM_RD, 16'h0011, 1'b0);
    check("masked int", 16'h0000, 16'(akd));
    @(posedge clk_sys);
    ien <= 1'b1;
    run(BCS_CMD_FETCH, 16'h0012, 1'b1);
    run(BCS_CMD_FETCH, 16'h0013, 1'b0);
    check("ack seen", 16'h0001, 16'(akd));
    check("vector", 16'h00c4, 16'(rd));
    check("ack waits", 16'h0004, 16'(lat - l_fetch));
    @(posedge clk_sys);
    int_n <= 1'b1;
    ien <= 1'b0;
  endtask : t_int
  task automatic t_bus();
    fork
      run(BCS_CMD_MEM_RD, 16'h0040, 1'b0);
      begin
        repeat (4) @(posedge clk_sys);
        bus_request_n <= 1'b0;
      end
    join
    for (int i = 0; i < 30 && bus_grant_n; i++) @(posedge clk_sys) #1;
    check("grant", 16'h0000, 16'(bus_grant_n));
    check("address float", 16'h0000, 16'(addr_oe));
    repeat (20) @(posedge clk_sys);
    bus_request_n <= 1'b1;
    for (int i = 0; i < 30 && !cyc_ready; i++) @(posedge clk_sys) #1;
    check("release", 16'h0001, 16'(bus_grant_n));
  endtask : t_bus
  initial begin
    #240000;
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_fetch();
    t_mem_io();
    t_int();
    t_bus();
    give_verdict();
  end
endmodule : testbench
